// File: utx_map.svh
// register offsets, field positions, reset values and frame counts
`ifndef UTX_MAP_SVH
`define UTX_MAP_SVH

// ================================================================
// register byte offsets
`define UTX_OFF_DATA      8'h00
`define UTX_OFF_CTRL      8'h04
`define UTX_OFF_STATUS    8'h08
`define UTX_OFF_MASK      8'h0C
`define UTX_OFF_PORT      8'h10

// ================================================================
// control register fields
`define UTX_CTRL_EN       0
`define UTX_CTRL_NINE     1
`define UTX_CTRL_BIT8     2
`define UTX_CTRL_RST      3'h0

// ================================================================
// status and mask register fields
`define UTX_STAT_EMPTY    0
`define UTX_STAT_DONE     1
`define UTX_MASK_RST      2'h0

// ================================================================
// port register fields
`define UTX_PORT_DIR      0
`define UTX_PORT_LEVEL    1
`define UTX_PORT_PIN      2
`define UTX_PORT_RST      2'h0

// ================================================================
// frame lengths in bit periods, start and stop included
`define UTX_LEN_EIGHT     4'hA
`define UTX_LEN_NINE      4'hB

`endif

// File: utx_pkg.sv
// types shared by the transmitter modules
package utx_pkg;

  // ================================================================
  // shifter states, one-hot
  typedef enum logic [1:0] {
    UTX_ST_IDLE  = 2'b01,
    UTX_ST_SHIFT = 2'b10
  } utx_state_e;

  typedef logic [7:0]  utx_byte_t;
  typedef logic [10:0] utx_frame_t;

endpackage

// File: utx_shift_if.sv
// link between the register side and the frame shifter
`timescale 1ns/1ps
interface utx_shift_if;
  logic              load;
  utx_pkg::utx_byte_t data;
  logic              nine;
  logic              bit8;
  logic              tick;
  logic              enable;
  logic              frame_end;
  logic              idle;
  logic              txd;

  modport ctrl  (output load, data, nine, bit8, tick, enable,
                 input  frame_end, idle, txd);
  modport shift (input  load, data, nine, bit8, tick, enable,
                 output frame_end, idle, txd);
endinterface

// File: utx_shifter.sv
// frame shift register: start bit, data lsb first, optional ninth bit, stop
`timescale 1ns/1ps
`include "utx_map.svh"
module utx_shifter (
  // clock, reset and clock enable
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic ce_in,
  // register side
  utx_shift_if.shift link
);
  import utx_pkg::*;

  utx_state_e state;
  utx_state_e next_state;
  utx_frame_t sr;
  utx_frame_t next_sr;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [3:0] len;
  logic [3:0] next_len;
  logic       txd;
  logic       next_txd;

  // ================================================================
  // decode
  wire        shifting = (state == UTX_ST_SHIFT);
  wire        bit_tick = shifting && link.tick;
  wire        stop_bit = link.nine ? link.bit8 : 1'b1;
  wire utx_frame_t load_frame = {1'b1, stop_bit, link.data, 1'b0};
  wire [3:0]  load_len = link.nine ? `UTX_LEN_NINE : `UTX_LEN_EIGHT;

  assign link.frame_end = bit_tick && (cnt == len);
  assign link.idle      = (state == UTX_ST_IDLE);
  assign link.txd       = txd;

  always_comb begin
    next_state = state;
    next_sr    = sr;
    next_cnt   = cnt;
    next_len   = len;
    next_txd   = txd;
    case (state)
      UTX_ST_IDLE: begin
        next_txd = 1'b1;
      end
      UTX_ST_SHIFT: begin
        if (bit_tick && (cnt == len)) begin
          // stop bit has stood one full period
          next_state = UTX_ST_IDLE;
        end else if (bit_tick) begin
          next_txd = sr[0];
          next_sr  = {1'b1, sr[10:1]};
          next_cnt = 4'(cnt + 4'h1);
        end
      end
      default: begin
        next_state = UTX_ST_IDLE;
      end
    endcase
    if (link.load) begin
      next_state = UTX_ST_SHIFT;
      next_sr    = load_frame;
      next_cnt   = 4'h0;
      next_len   = load_len;
    end
    if (!link.enable) begin
      next_state = UTX_ST_IDLE;
      next_txd   = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= UTX_ST_IDLE;
      sr    <= 11'h7FF;
      cnt   <= 4'h0;
      len   <= `UTX_LEN_EIGHT;
      txd   <= 1'b1;
    end else if (ce_in) begin
      state <= next_state;
      sr    <= next_sr;
      cnt   <= next_cnt;
      len   <= next_len;
      txd   <= next_txd;
    end
  end

  // ================================================================
  // checks
  a_start_bit_low: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ce_in && link.load && link.enable |=> sr[0] == 1'b0 && cnt == 4'h0)
    else $error("start bit not cleared at load");
  a_stop_bit_high: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ce_in && link.load && link.enable && !link.nine |=> sr[9] && sr[10])
    else $error("stop bit not set at load");
  a_ninth_bit_copy: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ce_in && link.load && link.enable && link.nine
    |=> sr[9] == $past(link.bit8) && sr[10])
    else $error("ninth bit not copied");
  a_first_tick_start: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ce_in && bit_tick && cnt == 4'h0 && link.enable && !link.load
    |=> txd == 1'b0)
    else $error("start bit not driven on first tick");
  a_lsb_first_order: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ce_in && bit_tick && cnt != len && link.enable && !link.load
    |=> txd == $past(sr[0]) && cnt == 4'($past(cnt) + 4'h1))
    else $error("bits not shifted lsb first");
endmodule // utx_shifter

// File: utx_top.sv
// asynchronous serial transmitter with apb registers and shared pin
//
// Overview of operation
// - when the shift register is empty, load the holding byte and set empty
// - load forces bit 0 low as start, bit 9 or 10 high as stop
// - in nine-bit mode copy the ninth transmit bit into shift bit 9
// - first baud tick after load drives the start bit, then one bit a tick
// - data bits go out least significant first between start and stop
// - after the stop bit, reload a pending byte and set the empty flag
// - with nothing pending, empty flag stays set until the next data write
// - no pending byte and stop held one bit period: set transmit complete
// - transmitter works only while enabled, else pin is plain port i/o
// - enabled transmitter owns the pin as output, direction bit ignored
`timescale 1ns/1ps
`include "utx_map.svh"
module utx_top (
  // clock, reset, clock enable
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic             ce_in,
  // apb slave
  input  wire logic             psel_in,
  input  wire logic             penable_in,
  input  wire logic             pwrite_in,
  input  wire logic [7:0]       paddr_in,
  input  wire logic [31:0]      pwdata_in,
  output logic      [31:0]      prdata_out,
  output logic                  pready_out,
  output logic                  pslverr_out,
  // baud rate tick, one clock wide
  input  wire logic             baud_tick_in,
  // shared port pin
  input  wire logic             pin_in,
  output logic                  pin_out,
  output logic                  pin_oe_n_out,
  // interrupt
  output logic                  irq_out
);
  import utx_pkg::*;

  // ================================================================
  // register state
  utx_byte_t  tx_data_holding;
  logic       holding_empty_flag;
  logic       tx_complete_flag;
  logic       tx_enable_bit;
  logic       nine_bit_select;
  logic       ninth_tx_bit;
  logic [1:0] irq_mask;
  logic       pin_direction_bit;
  logic       pin_level_bit;

  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        next_empty;
  logic        next_done;
  logic        next_pin;
  logic        next_oe_n;

  utx_shift_if link ();

  utx_shifter u_shifter (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .ce_in     (ce_in),
    .link      (link)
  );

  // ================================================================
  // apb decode
  // one wait state: pready rises in the second access cycle
  wire access    = psel_in && penable_in && !pready_out;
  wire wr_access = access && pwrite_in;
  wire rd_access = access && !pwrite_in;
  wire hit_data  = (paddr_in == `UTX_OFF_DATA);
  wire hit_ctrl  = (paddr_in == `UTX_OFF_CTRL);
  wire hit_stat  = (paddr_in == `UTX_OFF_STATUS);
  wire hit_mask  = (paddr_in == `UTX_OFF_MASK);
  wire hit_port  = (paddr_in == `UTX_OFF_PORT);
  wire hit_any   = hit_data || hit_ctrl || hit_stat || hit_mask || hit_port;
  wire wr_data   = wr_access && hit_data;
  wire wr_ctrl   = wr_access && hit_ctrl;
  wire wr_stat   = wr_access && hit_stat;
  wire wr_mask   = wr_access && hit_mask;
  wire wr_port   = wr_access && hit_port;

  wire [1:0] status_bits = {tx_complete_flag, holding_empty_flag};
  wire [2:0] ctrl_bits   = {ninth_tx_bit, nine_bit_select, tx_enable_bit};
  wire [2:0] port_bits   = {pin_in, pin_level_bit, pin_direction_bit};

  always_comb begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = access && !hit_any;
    if (rd_access) begin
      case (1'b1)
        hit_data: next_prdata = {24'h00_0000, tx_data_holding};
        hit_ctrl: next_prdata = {29'h000_0000, ctrl_bits};
        hit_stat: next_prdata = {30'h000_0000, status_bits};
        hit_mask: next_prdata = {30'h000_0000, irq_mask};
        hit_port: next_prdata = {29'h000_0000, port_bits};
        default:  next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // ================================================================
  // shifter control
  // a byte is pending while the holding flag reads zero
  wire pending   = !holding_empty_flag;
  wire sr_free   = link.idle || link.frame_end;
  wire load_now  = tx_enable_bit && pending && sr_free;

  assign link.load   = load_now;
  assign link.data   = tx_data_holding;
  assign link.nine   = nine_bit_select;
  assign link.bit8   = ninth_tx_bit;
  assign link.tick   = baud_tick_in;
  assign link.enable = tx_enable_bit;

  // a write in the load cycle makes a fresh byte pending again
  always_comb begin
    next_empty = holding_empty_flag;
    if (load_now) begin
      next_empty = 1'b1;
    end
    if (wr_data) begin
      next_empty = 1'b0;
    end
  end

  // set wins over a write-one clear in the same cycle
  wire done_event = link.frame_end && !pending;
  always_comb begin
    next_done = tx_complete_flag;
    if (wr_stat && pwdata_in[`UTX_STAT_DONE]) begin
      next_done = 1'b0;
    end
    if (done_event) begin
      next_done = 1'b1;
    end
  end

  // ================================================================
  // pin ownership
  always_comb begin
    if (tx_enable_bit) begin
      next_pin  = link.txd;
      next_oe_n = 1'b0;
    end else begin
      next_pin  = pin_level_bit;
      next_oe_n = !pin_direction_bit;
    end
  end

  wire next_irq = |(status_bits & irq_mask);

  // ================================================================
  // registers
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else if (ce_in) begin
      pready_out  <= access;
      pslverr_out <= next_pslverr;
      prdata_out  <= next_prdata;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_data_holding <= 8'h00;
    end else if (ce_in && wr_data) begin
      tx_data_holding <= pwdata_in[7:0];
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      {ninth_tx_bit, nine_bit_select, tx_enable_bit} <= `UTX_CTRL_RST;
    end else if (ce_in && wr_ctrl) begin
      tx_enable_bit   <= pwdata_in[`UTX_CTRL_EN];
      nine_bit_select <= pwdata_in[`UTX_CTRL_NINE];
      ninth_tx_bit    <= pwdata_in[`UTX_CTRL_BIT8];
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_mask                           <= `UTX_MASK_RST;
      {pin_level_bit, pin_direction_bit} <= `UTX_PORT_RST;
    end else if (ce_in) begin
      if (wr_mask) begin
        irq_mask <= pwdata_in[1:0];
      end
      if (wr_port) begin
        pin_direction_bit <= pwdata_in[`UTX_PORT_DIR];
        pin_level_bit     <= pwdata_in[`UTX_PORT_LEVEL];
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      holding_empty_flag <= 1'b1;
      tx_complete_flag   <= 1'b0;
      irq_out            <= 1'b0;
    end else if (ce_in) begin
      holding_empty_flag <= next_empty;
      tx_complete_flag   <= next_done;
      irq_out            <= next_irq;
    end
  end

  // pin is an input after reset so nothing is driven before software acts
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_out      <= 1'b1;
      pin_oe_n_out <= 1'b1;
    end else if (ce_in) begin
      pin_out      <= next_pin;
      pin_oe_n_out <= next_oe_n;
    end
  end

  // ================================================================
  // checks
  a_load_sets_empty: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ce_in && load_now && !wr_data |=> holding_empty_flag)
    else $error("empty flag not set on load");
  a_reload_after_stop: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ce_in && link.frame_end && pending && tx_enable_bit
    |=> !link.idle && link.txd)
    else $error("pending byte not reloaded after stop");
  a_empty_stays_set: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ce_in && holding_empty_flag && !wr_data |=> holding_empty_flag)
    else $error("empty flag dropped without a data write");
  a_data_write_clears: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ce_in && wr_data |=> !holding_empty_flag)
    else $error("data write left the empty flag set");
  a_done_on_stop: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ce_in && link.frame_end && !pending |=> tx_complete_flag)
    else $error("complete flag not set after stop period");
  a_done_stays_set: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ce_in && tx_complete_flag && !wr_stat |=> tx_complete_flag)
    else $error("complete flag dropped without a clear");
  // a spurious complete flag would let software drop the line too early
  a_done_needs_stop: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ce_in && !tx_complete_flag && !done_event |=> !tx_complete_flag)
    else $error("complete flag set without a finished frame");
  a_pin_gpio_when_off: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ce_in && !tx_enable_bit
    |=> pin_oe_n_out == !$past(pin_direction_bit)
        && pin_out == $past(pin_level_bit))
    else $error("pin not returned to port use");
  a_pin_forced_out: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ce_in && tx_enable_bit |=> !pin_oe_n_out)
    else $error("enabled transmitter not driving pin");
  a_pin_follows_tx: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ce_in && tx_enable_bit |=> pin_out == $past(link.txd))
    else $error("enabled pin does not carry the serial output");
  a_idle_line_high: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ce_in && tx_enable_bit && link.idle && !load_now
    ##1 ce_in && tx_enable_bit |=> pin_out)
    else $error("idle line not high");

  // ================================================================
  // bus and interrupt checks
  // the answer is fixed at one wait state, so masters may rely on it
  a_one_wait_state: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ce_in && access |=> pready_out)
    else $error("access not answered after one wait state");
  a_no_ready_idle: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ce_in && !(psel_in && penable_in) |=> !pready_out)
    else $error("ready raised without an access");
  a_unmapped_error: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ce_in && access && !hit_any |=> pslverr_out && pready_out)
    else $error("unmapped access not flagged");
  // read data is zero outside a read so a stale word never leaks
  a_read_data_quiet: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ce_in && !rd_access |=> prdata_out == 32'h0000_0000)
    else $error("read data not zero outside a read");
  a_irq_follows_mask: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ce_in |=> irq_out == |($past(status_bits) & $past(irq_mask)))
    else $error("interrupt output mismatch");
endmodule // utx_top

// File: utx_rx_model.sv
// remote serial receiver that decodes frames seen on the transmit line
`timescale 1ns/1ps
module utx_rx_model (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  // line side
  input  wire logic       tick_in,
  input  wire logic       line_in,
  input  wire logic       drive_in,
  input  wire logic       nine_in,
  // decoded frame
  output logic      [7:0] count_out,
  output logic      [7:0] byte_out,
  output logic            ninth_out,
  output logic            stop_ok_out
);
  // ================================================================
  // receiver
  // position 0 waits for a start bit, 1..8 data, 9 the ninth bit when nine_in, then the stop bit
  logic [3:0] pos;
  logic [8:0] sh;

  // sampling on the tick edge sees the bit launched by the previous tick,
  // so the tick period must exceed the two-clock output latency
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pos         <= 4'h0;
      sh          <= 9'h000;
      count_out   <= 8'h00;
      byte_out    <= 8'h00;
      ninth_out   <= 1'b0;
      stop_ok_out <= 1'b0;
    end else if (!drive_in) begin
      pos <= 4'h0;
    end else if (tick_in) begin
      if (pos == 4'h0) begin
        if (line_in === 1'b0) begin
          pos <= 4'h1;
        end
      end else if (pos <= 4'h8 || (nine_in && pos == 4'h9)) begin
        sh[pos - 4'h1] <= line_in;
        pos            <= pos + 4'h1;
      end else begin
        byte_out    <= sh[7:0];
        ninth_out   <= nine_in & sh[8];
        stop_ok_out <= line_in;
        count_out   <= count_out + 8'h01;
        pos         <= 4'h0;
      end
    end
  end
endmodule // utx_rx_model

// File: test_uart_transmitter.sv
// self-checking bench for the serial transmitter
`timescale 1ns/1ps
`include "utx_map.svh"
module test_uart_transmitter;
  import utx_pkg::*;
  // ================================================================
  // signals
  logic        clk_in, resetn_in, psel, penable, pwrite, baud_tick;
  logic        pready, pslverr, pin_out, pin_oe_n, irq, line, ext_level;
  logic [7:0]  paddr, rx_count, rx_byte, exp_frames;
  logic [31:0] pwdata, prdata, rdata;
  logic        rx_ninth, rx_stop, rx_nine, rslverr;
  logic [2:0]  tick_div;
  int          err_count, comparisons, cycles;

  // undriven pin rests at the pull-up level
  assign line = pin_oe_n ? ext_level : pin_out;

  utx_top uut (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(1'b1),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr),
    .baud_tick_in(baud_tick), .pin_in(line), .pin_out(pin_out),
    .pin_oe_n_out(pin_oe_n), .irq_out(irq));

  utx_rx_model partner (.clk_in(clk_in), .resetn_in(resetn_in),
    .tick_in(baud_tick), .line_in(line), .drive_in(!pin_oe_n),
    .nine_in(rx_nine), .count_out(rx_count), .byte_out(rx_byte),
    .ninth_out(rx_ninth), .stop_ok_out(rx_stop));

  // ================================================================
  // clock, baud tick every eight clocks, watchdog
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    tick_div  <= tick_div + 3'h1;
    baud_tick <= (tick_div == 3'h6);
    cycles    <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end

  // ================================================================
  // shared tasks
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
    end
    rdata   = prdata;
    rslverr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic wait_rx();
    int i;
    i = 0;
    exp_frames = exp_frames + 8'h01;
    while (rx_count !== exp_frames && i < 2000) begin
      @(posedge clk_in);
      i++;
    end
    check("frame count", rx_count, exp_frames);
    check("stop bit", rx_stop, 1'b1);
  endtask

  task automatic poll_done();
    int i;
    i = 0;
    apb(1'b0, `UTX_OFF_STATUS, 32'h0);
    while (rdata[1] !== 1'b1 && i < 40) begin
      apb(1'b0, `UTX_OFF_STATUS, 32'h0);
      i++;
    end
    check("status done", rdata, 32'h0000_0003);
    apb(1'b1, `UTX_OFF_STATUS, 32'h0000_0002);
  endtask

  task automatic pause(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // ================================================================
  // scenarios
  task automatic t_reset();
    check("oe after reset", pin_oe_n, 1'b1);
    apb(1'b0, `UTX_OFF_CTRL, 32'h0);
    check("ctrl reset", rdata, 32'h0000_0000);
    check("mapped err", rslverr, 1'b0);
    apb(1'b0, `UTX_OFF_STATUS, 32'h0);
    check("status reset", rdata, 32'h0000_0001);
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped err", rslverr, 1'b1);
    check("unmapped data", rdata, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_port();
    apb(1'b1, `UTX_OFF_PORT, 32'h0000_0001);
    pause(2);
    check("port oe", pin_oe_n, 1'b0);
    check("port level", pin_out, 1'b0);
    apb(1'b0, `UTX_OFF_PORT, 32'h0);
    check("port pin low", rdata, 32'h0000_0001);
    apb(1'b1, `UTX_OFF_PORT, 32'h0000_0003);
    pause(2);
    check("port level high", pin_out, 1'b1);
    apb(1'b1, `UTX_OFF_PORT, 32'h0000_0000);
    pause(2);
    check("port released", pin_oe_n, 1'b1);
    apb(1'b0, `UTX_OFF_PORT, 32'h0);
    check("port read", rdata, 32'h0000_0004);
    apb(1'b1, `UTX_OFF_CTRL, 32'h0000_0001);
    pause(2);
    check("tx owns pin", pin_oe_n, 1'b0);
    check("idle high", pin_out, 1'b1);
    $display("test port done");
  endtask

  task automatic t_frame8();
    apb(1'b1, `UTX_OFF_DATA, 32'h0000_00A5);
    apb(1'b0, `UTX_OFF_STATUS, 32'h0);
    check("loaded empty", rdata, 32'h0000_0001);
    wait_rx();
    check("byte", rx_byte, 8'hA5);
    check("ninth", rx_ninth, 1'b0);
    poll_done();
    apb(1'b0, `UTX_OFF_STATUS, 32'h0);
    check("done cleared", rdata, 32'h0000_0001);
    $display("test frame8 done");
  endtask

  task automatic t_b2b();
    apb(1'b1, `UTX_OFF_DATA, 32'h0000_003C);
    apb(1'b1, `UTX_OFF_DATA, 32'h0000_0081);
    apb(1'b0, `UTX_OFF_STATUS, 32'h0);
    check("pending", rdata, 32'h0000_0000);
    wait_rx();
    check("first byte", rx_byte, 8'h3C);
    apb(1'b0, `UTX_OFF_STATUS, 32'h0);
    check("reloaded", rdata, 32'h0000_0001);
    wait_rx();
    check("second byte", rx_byte, 8'h81);
    poll_done();
    $display("test b2b done");
  endtask

  task automatic t_nine();
    for (int b = 0; b < 2; b++) begin
      rx_nine <= 1'b1;
      apb(1'b1, `UTX_OFF_CTRL, {29'h0, b[0], 2'h3});
      apb(1'b1, `UTX_OFF_DATA, 32'h0000_00C6);
      wait_rx();
      check("nine byte", rx_byte, 8'hC6);
      check("ninth bit", rx_ninth, b[0]);
      poll_done();
    end
    apb(1'b1, `UTX_OFF_CTRL, 32'h0000_0001);
    rx_nine <= 1'b0;
    $display("test nine done");
  endtask

  task automatic t_irq();
    apb(1'b1, `UTX_OFF_MASK, 32'h0000_0001);
    pause(3);
    check("irq empty", irq, 1'b1);
    apb(1'b1, `UTX_OFF_MASK, 32'h0000_0002);
    pause(3);
    check("irq masked", irq, 1'b0);
    apb(1'b1, `UTX_OFF_DATA, 32'h0000_0011);
    wait_rx();
    pause(30);
    check("irq done", irq, 1'b1);
    apb(1'b1, `UTX_OFF_STATUS, 32'h0000_0002);
    pause(3);
    check("irq cleared", irq, 1'b0);
    apb(1'b1, `UTX_OFF_MASK, 32'h0000_0000);
    $display("test irq done");
  endtask

  task automatic t_abort();
    apb(1'b1, `UTX_OFF_DATA, 32'h0000_00C3);
    pause(40);
    apb(1'b1, `UTX_OFF_CTRL, 32'h0000_0000);
    pause(2);
    check("abort releases", pin_oe_n, 1'b1);
    pause(100);
    check("no frame", rx_count, exp_frames);
    apb(1'b1, `UTX_OFF_CTRL, 32'h0000_0001);
    pause(2);
    check("retake pin", pin_oe_n, 1'b0);
    check("idle again", pin_out, 1'b1);
    $display("test abort done");
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ================================================================
  // main sequence
  initial begin
    err_count   = 0;
    comparisons = 0;
    cycles      = 0;
    tick_div    = 3'h0;
    baud_tick   = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0000_0000;
    ext_level   = 1'b1;
    rx_nine     = 1'b0;
    exp_frames  = 8'h00;
    resetn_in   = 1'b0;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    t_reset();
    t_port();
    t_frame8();
    t_b2b();
    t_nine();
    t_irq();
    t_abort();
    finish_test();
  end
endmodule // test_uart_transmitter
